// [design/pll_clock_select_config.sv]
// Clock configuration registers, behavioural PLL and clock-enable routing
// Notes on behaviour
// - Bypass bit 7 of the first clock register routes the reference around the PLL while the PLL keeps running.
// - ADC halving bit 5 resets low for an undivided ADC source and divides that source by 2 when high.
// - Timing-mode bit 4 resets low so the reference drives receive path and ADCs, and high selects the transmit source, the PLL output unless bypassed.
// - Fifth-divider bit 3 resets low for an undivided PLL output and divides the PLL output by 5 when high.
// - The multiplier bits 2 to 0 reset to 000 for 1x, codes 001 to 100 give 2x to 16x, and 101 to 111 are unused.
// - The PLL output rate is the reference rate times the multiplier, further divided by five when selected.
// - Bit 5 of the second clock register replaces the second interface pin signal with the transmit clock, the PLL output clock unless bypassed.
// - Bit 2 of the second clock register selects the alternate, slower loop bandwidth.
// - Duplex bit 4 of I/O register 14 selects full duplex when high and resets high.
`timescale 1ns/1ps
module pll_clock_select_config (
	// Clock and reset
	input  wire logic                              sys_clk_i,
	input  wire logic                              rst_b_i,
	// Register port
	input  wire logic [clock_config_pkg::ADDR_W-1:0] reg_addr_i,
	input  wire logic [clock_config_pkg::DATA_W-1:0] reg_wdata_i,
	input  wire logic                              reg_wr_i,
	input  wire logic                              reg_rd_i,
	output logic      [clock_config_pkg::DATA_W-1:0] reg_rdata_o,
	// Reference and pin
	input  wire logic                              reference_clock_input_i,
	input  wire logic                              second_interface_pin_normal_i,
	output logic                                   second_interface_pin_o,
	// Clock enables
	output logic                                   tx_clk_en_o,
	output logic                                   rx_clk_en_o,
	output logic                                   adc_clk_en_o,
	// Mode outputs
	output logic                                   duplex_select_o,
	output logic                                   pll_slow_loop_o
);
	import clock_config_pkg::*;

	// Configuration fields
	logic              bypass_r, bypass_nxt;
	logic              adc_half_r, adc_half_nxt;
	logic              alt_timing_r, alt_timing_nxt;
	logic              fifth_div_r, fifth_div_nxt;
	logic [MULT_W-1:0] mult_r, mult_nxt;
	logic              pin_switch_r, pin_switch_nxt;
	logic              slow_loop_r, slow_loop_nxt;
	logic              duplex_r, duplex_nxt;
	logic [DATA_W-1:0] rdata_r, rdata_nxt;
	logic [DATA_W-1:0] pll_setup_view;
	logic [DATA_W-1:0] routing_view;
	logic [DATA_W-1:0] io_view;

	always_comb begin
		pll_setup_view                  = '0;
		pll_setup_view[BYPASS_BIT]      = bypass_r;
		pll_setup_view[ADC_HALF_BIT]    = adc_half_r;
		pll_setup_view[ALT_TIMING_BIT]  = alt_timing_r;
		pll_setup_view[FIFTH_DIV_BIT]   = fifth_div_r;
		pll_setup_view[MULT_LSB+:MULT_W] = mult_r;
		routing_view                    = '0;
		routing_view[PIN_SWITCH_BIT]    = pin_switch_r;
		routing_view[SLOW_LOOP_BIT]     = slow_loop_r;
		io_view                         = '0;
		io_view[DUPLEX_BIT]             = duplex_r;
	end

	always_comb begin
		bypass_nxt     = bypass_r;
		adc_half_nxt   = adc_half_r;
		alt_timing_nxt = alt_timing_r;
		fifth_div_nxt  = fifth_div_r;
		mult_nxt       = mult_r;
		pin_switch_nxt = pin_switch_r;
		slow_loop_nxt  = slow_loop_r;
		duplex_nxt     = duplex_r;
		rdata_nxt      = rdata_r;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				PLL_SETUP_OFFSET: begin
					bypass_nxt     = reg_wdata_i[BYPASS_BIT];
					adc_half_nxt   = reg_wdata_i[ADC_HALF_BIT];
					alt_timing_nxt = reg_wdata_i[ALT_TIMING_BIT];
					fifth_div_nxt  = reg_wdata_i[FIFTH_DIV_BIT];
					mult_nxt       = reg_wdata_i[MULT_LSB+:MULT_W];
				end
				ROUTING_OFFSET: begin
					pin_switch_nxt = reg_wdata_i[PIN_SWITCH_BIT];
					slow_loop_nxt  = reg_wdata_i[SLOW_LOOP_BIT];
				end
				IO_CONFIG_OFFSET: begin
					duplex_nxt = reg_wdata_i[DUPLEX_BIT];
				end
				default: begin
				end
			endcase
		end
		if (reg_rd_i) begin
			unique case (reg_addr_i)
				PLL_SETUP_OFFSET: rdata_nxt = pll_setup_view;
				ROUTING_OFFSET:   rdata_nxt = routing_view;
				IO_CONFIG_OFFSET: rdata_nxt = io_view;
				default:          rdata_nxt = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bypass_r     <= PLL_SETUP_RESET[BYPASS_BIT];
			adc_half_r   <= PLL_SETUP_RESET[ADC_HALF_BIT];
			alt_timing_r <= PLL_SETUP_RESET[ALT_TIMING_BIT];
			fifth_div_r  <= PLL_SETUP_RESET[FIFTH_DIV_BIT];
			mult_r       <= PLL_SETUP_RESET[MULT_LSB+:MULT_W];
			pin_switch_r <= ROUTING_RESET[PIN_SWITCH_BIT];
			slow_loop_r  <= ROUTING_RESET[SLOW_LOOP_BIT];
			duplex_r     <= IO_CONFIG_RESET[DUPLEX_BIT];
			rdata_r      <= '0;
		end else begin
			bypass_r     <= bypass_nxt;
			adc_half_r   <= adc_half_nxt;
			alt_timing_r <= alt_timing_nxt;
			fifth_div_r  <= fifth_div_nxt;
			mult_r       <= mult_nxt;
			pin_switch_r <= pin_switch_nxt;
			slow_loop_r  <= slow_loop_nxt;
			duplex_r     <= duplex_nxt;
			rdata_r      <= rdata_nxt;
		end
	end

	// Reference pin synchroniser and edge detect
	logic [2:0] ref_sync_r, ref_sync_nxt;
	logic       ref_level_r, ref_level_nxt;
	logic       ref_edge;

	always_comb begin
		ref_sync_nxt  = {ref_sync_r[1:0], reference_clock_input_i};
		ref_level_nxt = (ref_sync_r[1] == ref_sync_r[2]) ? ref_sync_r[2] : ref_level_r;
		ref_edge      = ref_sync_r[1] & ref_sync_r[2] & ~ref_level_r;
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ref_sync_r  <= '0;
			ref_level_r <= 1'b0;
		end else begin
			ref_sync_r  <= ref_sync_nxt;
			ref_level_r <= ref_level_nxt;
		end
	end

	// Behavioural PLL: measures reference period, emits 2 to the power mult ticks per period for mult up to 4, one tick above that
	logic [PERIOD_W-1:0] meas_r, meas_nxt;
	logic [PERIOD_W-1:0] est_r, est_nxt;
	logic [PERIOD_W-1:0] syn_cnt_r, syn_cnt_nxt;
	logic [PERIOD_W-1:0] step;
	logic [PERIOD_W:0]   avg_sum;
	logic                synth_tick_r, synth_tick_nxt;
	logic                ref_tick_r;

	always_comb begin
		step = (mult_r <= MULT_MAX_CODE) ? (est_r >> mult_r) : est_r;
		if (step == '0) begin
			step = PERIOD_W'(1);
		end
		avg_sum        = {1'b0, est_r} + {1'b0, meas_r} + 1'b1;
		meas_nxt       = (meas_r == '1) ? meas_r : meas_r + 1'b1;
		est_nxt        = est_r;
		syn_cnt_nxt    = syn_cnt_r + 1'b1;
		synth_tick_nxt = 1'b0;
		if (ref_edge) begin
			meas_nxt       = '0;
			est_nxt        = slow_loop_r ? avg_sum[PERIOD_W:1] : meas_r + 1'b1;
			syn_cnt_nxt    = '0;
			synth_tick_nxt = (est_r != '0);
		end else if (syn_cnt_r + 1'b1 >= step) begin
			syn_cnt_nxt    = '0;
			synth_tick_nxt = (est_r != '0);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meas_r       <= '0;
			est_r        <= '0;
			syn_cnt_r    <= '0;
			synth_tick_r <= 1'b0;
			ref_tick_r   <= 1'b0;
		end else begin
			meas_r       <= meas_nxt;
			est_r        <= est_nxt;
			syn_cnt_r    <= syn_cnt_nxt;
			synth_tick_r <= synth_tick_nxt;
			ref_tick_r   <= ref_edge;
		end
	end

	// Output divider and routing
	logic pll_clk_tick;
	logic tx_sel;
	logic rx_sel;
	logic tx_r, rx_r;
	logic pin_level_r, pin_level_nxt;
	logic pin_r, pin_nxt;

	tick_divider #(
		.RATIO     (FIFTH_RATIO)
	) u_fifth_div (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.div_en_i  (fifth_div_r),
		.tick_i    (synth_tick_r),
		.tick_o    (pll_clk_tick)
	);

	always_comb begin
		tx_sel        = bypass_r ? ref_tick_r : pll_clk_tick;
		rx_sel        = alt_timing_r ? tx_sel : ref_tick_r;
		pin_level_nxt = tx_sel ? ~pin_level_r : pin_level_r;
		pin_nxt       = pin_switch_r ? pin_level_r : second_interface_pin_normal_i;
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_r        <= 1'b0;
			rx_r        <= 1'b0;
			pin_level_r <= 1'b0;
			pin_r       <= 1'b0;
		end else begin
			tx_r        <= tx_sel;
			rx_r        <= rx_sel;
			pin_level_r <= pin_level_nxt;
			pin_r       <= pin_nxt;
		end
	end

	tick_divider #(
		.RATIO     (HALF_RATIO)
	) u_adc_half (
		.sys_clk_i (sys_clk_i),
		.rst_b_i   (rst_b_i),
		.div_en_i  (adc_half_r),
		.tick_i    (rx_sel),
		.tick_o    (adc_clk_en_o)
	);

	assign reg_rdata_o            = rdata_r;
	assign second_interface_pin_o = pin_r;
	assign tx_clk_en_o            = tx_r;
	assign rx_clk_en_o            = rx_r;
	assign duplex_select_o        = duplex_r;
	assign pll_slow_loop_o        = slow_loop_r;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	chk_bypass_route: assert property (bypass_r && $past(bypass_r) |-> tx_clk_en_o == $past(ref_tick_r))
		else $error("tx enable not from reference in bypass");
	chk_adc_direct: assert property (!adc_half_r && $past(!adc_half_r) |-> adc_clk_en_o == $past(rx_sel))
		else $error("adc enable not undivided source");
	chk_adc_halved: assert property (adc_half_r && adc_clk_en_o |=> !adc_clk_en_o)
		else $error("adc enable not halved");
	chk_rx_normal: assert property (!alt_timing_r ##1 !alt_timing_r |-> rx_clk_en_o == $past(ref_tick_r))
		else $error("rx enable not from reference");
	chk_fifth_off: assert property (!fifth_div_r && $past(!fifth_div_r) |-> pll_clk_tick == $past(synth_tick_r))
		else $error("pll output divided unexpectedly");
	chk_fifth_gap: assert property (fifth_div_r && pll_clk_tick ##1 fifth_div_r[*3] |-> !pll_clk_tick)
		else $error("fifth divider too fast");
	chk_synth_step: assert property (synth_tick_r && !$past(ref_edge) |-> $past(syn_cnt_r) + 1'b1 >= $past(step))
		else $error("pll tick before step elapsed");
	chk_pin_switch: assert property (pin_switch_r && $past(pin_switch_r) |-> second_interface_pin_o == $past(pin_level_r))
		else $error("pin not carrying pll clock");
	chk_slow_average: assert property (ref_edge && slow_loop_r |=> est_r == PERIOD_W'(($past(avg_sum)) >> 1))
		else $error("slow loop estimate wrong");
	chk_duplex_write: assert property (reg_wr_i && reg_addr_i == IO_CONFIG_OFFSET |=> duplex_select_o == $past(reg_wdata_i[DUPLEX_BIT]))
		else $error("duplex bit not written");
	chk_read_back: assert property (reg_rd_i && reg_addr_i == PLL_SETUP_OFFSET |=> reg_rdata_o == $past(pll_setup_view))
		else $error("pll setup readback wrong");
endmodule : pll_clock_select_config

// [design/clock_config_pkg.sv]
// Package with register map, field positions and reset values of the clock block
package clock_config_pkg;
	localparam int         ADDR_W            = 8;
	localparam int         DATA_W            = 8;
	localparam int         PERIOD_W          = 16;
	localparam int         MULT_W            = 3;

	// Register offsets
	localparam logic [7:0] IO_CONFIG_OFFSET  = 8'h0e;
	localparam logic [7:0] PLL_SETUP_OFFSET  = 8'h0f;
	localparam logic [7:0] ROUTING_OFFSET    = 8'h10;

	// Field positions
	localparam int         DUPLEX_BIT        = 4;
	localparam int         BYPASS_BIT        = 7;
	localparam int         ADC_HALF_BIT      = 5;
	localparam int         ALT_TIMING_BIT    = 4;
	localparam int         FIFTH_DIV_BIT     = 3;
	localparam int         MULT_LSB          = 0;
	localparam int         PIN_SWITCH_BIT    = 5;
	localparam int         SLOW_LOOP_BIT     = 2;

	// Reset values
	localparam logic [7:0] IO_CONFIG_RESET   = 8'h10;
	localparam logic [7:0] PLL_SETUP_RESET   = 8'h00;
	localparam logic [7:0] ROUTING_RESET     = 8'h00;

	// Multiplier codes, code is log2 of the factor
	localparam logic [2:0] MULT_MAX_CODE     = 3'h4;

	// Output divider ratios
	localparam int         FIFTH_RATIO       = 5;
	localparam int         HALF_RATIO        = 2;
endpackage : clock_config_pkg

// [design/tick_divider.sv]
// Optional divider of a clock-enable pulse train
`timescale 1ns/1ps
module tick_divider #(
	parameter int RATIO = 2
) (
	// Clock and reset
	input  wire logic sys_clk_i,
	input  wire logic rst_b_i,
	// Pulse path
	input  wire logic div_en_i,
	input  wire logic tick_i,
	output logic      tick_o
);
	localparam int         CNT_W = (RATIO > 2) ? $clog2(RATIO) : 1;
	localparam logic [CNT_W-1:0] LAST = CNT_W'(RATIO - 1);

	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_nxt;
	logic             tick_r;
	logic             tick_nxt;

	always_comb begin
		cnt_nxt  = cnt_r;
		tick_nxt = tick_i;
		if (!div_en_i) begin
			cnt_nxt = '0;
		end else if (tick_i) begin
			tick_nxt = (cnt_r == LAST);
			cnt_nxt  = (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_r  <= '0;
			tick_r <= 1'b0;
		end else begin
			cnt_r  <= cnt_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign tick_o = tick_r;
endmodule : tick_divider

// [verif/pll_clock_select_config_tb_top.sv]
// Self-checking testbench of the clock configuration block
`timescale 1ns/1ps
module pll_clock_select_config_tb_top;
	import clock_config_pkg::*;

	logic              sys_clk_i;
	logic              rst_b_i;
	logic [ADDR_W-1:0] reg_addr_i;
	logic [DATA_W-1:0] reg_wdata_i;
	logic              reg_wr_i;
	logic              reg_rd_i;
	logic [DATA_W-1:0] reg_rdata_o;
	logic              reference_clock_input_i;
	logic              second_interface_pin_normal_i;
	logic              second_interface_pin_o;
	logic              tx_clk_en_o;
	logic              rx_clk_en_o;
	logic              adc_clk_en_o;
	logic              duplex_select_o;
	logic              pll_slow_loop_o;
	int                bad_count;
	int                checks_done;
	int                ref_cnt;

	pll_clock_select_config i_pll_clock_select_config (
		.sys_clk_i                     (sys_clk_i),
		.rst_b_i                       (rst_b_i),
		.reg_addr_i                    (reg_addr_i),
		.reg_wdata_i                   (reg_wdata_i),
		.reg_wr_i                      (reg_wr_i),
		.reg_rd_i                      (reg_rd_i),
		.reg_rdata_o                   (reg_rdata_o),
		.reference_clock_input_i       (reference_clock_input_i),
		.second_interface_pin_normal_i (second_interface_pin_normal_i),
		.second_interface_pin_o        (second_interface_pin_o),
		.tx_clk_en_o                   (tx_clk_en_o),
		.rx_clk_en_o                   (rx_clk_en_o),
		.adc_clk_en_o                  (adc_clk_en_o),
		.duplex_select_o               (duplex_select_o),
		.pll_slow_loop_o               (pll_slow_loop_o)
	);

	always #50 sys_clk_i = ~sys_clk_i;

	// Reference of 64 system cycles, so every multiplier divides it evenly
	always @(posedge sys_clk_i) begin
		ref_cnt <= (ref_cnt == 31) ? 0 : ref_cnt + 1;
		if (ref_cnt == 31) begin
			reference_clock_input_i <= ~reference_clock_input_i;
		end
	end

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp8

	task automatic cmp_bit(input string what, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask : cmp_bit

	task automatic cmp_cnt(input string what, input int exp, input int got);
		checks_done++;
		if (got != exp) begin
			bad_count++;
			$display("FAIL %s expected %0d seen %0d", what, exp, got);
		end
	endtask : cmp_cnt

	task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
		@(posedge sys_clk_i);
		reg_addr_i  <= addr;
		reg_wdata_i <= data;
		reg_wr_i    <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_i    <= 1'b0;
		#1;
	endtask : reg_write

	task automatic reg_check(input logic [7:0] addr, input logic [7:0] exp);
		@(posedge sys_clk_i);
		reg_addr_i <= addr;
		reg_rd_i   <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_i   <= 1'b0;
		@(posedge sys_clk_i);
		cmp8("register read", exp, reg_rdata_o);
	endtask : reg_check

	// Counts pulses and pin toggles over a window of whole pulse periods
	task automatic count_win(input int n, output int ntx, output int nrx, output int nadc, output int ntog);
		logic last;
		ntx  = 0;
		nrx  = 0;
		nadc = 0;
		ntog = 0;
		#1;
		last = second_interface_pin_o;
		repeat (n) begin
			@(posedge sys_clk_i);
			#1;
			ntx  += (tx_clk_en_o === 1'b1);
			nrx  += (rx_clk_en_o === 1'b1);
			nadc += (adc_clk_en_o === 1'b1);
			ntog += (second_interface_pin_o !== last);
			last = second_interface_pin_o;
		end
	endtask : count_win

	task automatic t_reset_values;
		cmp_bit("duplex at reset", 1'b1, duplex_select_o);
		cmp_bit("slow loop at reset", 1'b0, pll_slow_loop_o);
		reg_check(IO_CONFIG_OFFSET, 8'h10);
		reg_check(PLL_SETUP_OFFSET, 8'h00);
		reg_check(ROUTING_OFFSET, 8'h00);
	endtask : t_reset_values

	task automatic t_readback;
		reg_write(PLL_SETUP_OFFSET, 8'h88);
		reg_write(8'h11, 8'hff);
		reg_check(PLL_SETUP_OFFSET, 8'h88);
		reg_check(8'h11, 8'h00);
		reg_write(PLL_SETUP_OFFSET, 8'h07);
		reg_check(PLL_SETUP_OFFSET, 8'h07);
		reg_write(ROUTING_OFFSET, 8'hff);
		reg_check(ROUTING_OFFSET, 8'h24);
		cmp_bit("slow loop set", 1'b1, pll_slow_loop_o);
		reg_write(ROUTING_OFFSET, 8'h00);
		cmp_bit("slow loop clear", 1'b0, pll_slow_loop_o);
		reg_write(IO_CONFIG_OFFSET, 8'h00);
		reg_check(IO_CONFIG_OFFSET, 8'h00);
		cmp_bit("half duplex", 1'b0, duplex_select_o);
		reg_write(IO_CONFIG_OFFSET, 8'hff);
		reg_check(IO_CONFIG_OFFSET, 8'h10);
		cmp_bit("full duplex", 1'b1, duplex_select_o);
	endtask : t_readback

	task automatic rate_case(input logic [7:0] setup, input int etx, input int erx, input int eadc);
		int ntx, nrx, nadc, ntog;
		reg_write(PLL_SETUP_OFFSET, setup);
		repeat (256) @(posedge sys_clk_i);
		count_win(640, ntx, nrx, nadc, ntog);
		cmp_cnt("transmit pulses", etx, ntx);
		cmp_cnt("receive pulses", erx, nrx);
		cmp_cnt("converter pulses", eadc, nadc);
	endtask : rate_case

	task automatic t_rates;
		rate_case(8'h00, 10, 10, 10);
		rate_case(8'h01, 20, 10, 10);
		rate_case(8'h02, 40, 10, 10);
		rate_case(8'h03, 80, 10, 10);
		rate_case(8'h04, 160, 10, 10);
		rate_case(8'h0c, 32, 10, 10);
		rate_case(8'h14, 160, 160, 160);
		rate_case(8'h34, 160, 160, 80);
		rate_case(8'h20, 10, 10, 5);
		rate_case(8'h84, 10, 10, 10);
		rate_case(8'h1b, 16, 16, 16);
		reg_write(ROUTING_OFFSET, 8'h04);
		cmp_bit("slow loop for rate", 1'b1, pll_slow_loop_o);
		rate_case(8'h02, 40, 10, 10);
		reg_write(ROUTING_OFFSET, 8'h00);
	endtask : t_rates

	task automatic t_pin;
		int ntx, nrx, nadc, ntog;
		reg_write(PLL_SETUP_OFFSET, 8'h02);
		@(posedge sys_clk_i);
		second_interface_pin_normal_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		#1;
		cmp_bit("pin normal high", 1'b1, second_interface_pin_o);
		@(posedge sys_clk_i);
		second_interface_pin_normal_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		#1;
		cmp_bit("pin normal low", 1'b0, second_interface_pin_o);
		cmp_bit("full duplex before switch", 1'b1, duplex_select_o);
		reg_write(ROUTING_OFFSET, 8'h20);
		repeat (256) @(posedge sys_clk_i);
		count_win(640, ntx, nrx, nadc, ntog);
		cmp_cnt("pin toggles", 40, ntog);
		reg_write(ROUTING_OFFSET, 8'h00);
	endtask : t_pin

	// Reset in mid-run returns every field to its reset value
	task automatic t_mid_reset;
		reg_write(PLL_SETUP_OFFSET, 8'h9b);
		reg_write(ROUTING_OFFSET, 8'h24);
		reg_write(IO_CONFIG_OFFSET, 8'h00);
		@(posedge sys_clk_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		cmp_bit("duplex after reset", 1'b1, duplex_select_o);
		cmp_bit("slow loop after reset", 1'b0, pll_slow_loop_o);
		cmp_bit("tx enable after reset", 1'b0, tx_clk_en_o);
		reg_check(PLL_SETUP_OFFSET, PLL_SETUP_RESET);
		reg_check(ROUTING_OFFSET, ROUTING_RESET);
		reg_check(IO_CONFIG_OFFSET, IO_CONFIG_RESET);
	endtask : t_mid_reset

	// Watchdog against a hung run
	initial begin
		repeat (100000) @(posedge sys_clk_i);
		bad_count++;
		close_out();
	end

	initial begin
		sys_clk_i                     = 1'b0;
		rst_b_i                       = 1'b0;
		reg_addr_i                    = 8'h00;
		reg_wdata_i                   = 8'h00;
		reg_wr_i                      = 1'b0;
		reg_rd_i                      = 1'b0;
		reference_clock_input_i       = 1'b0;
		second_interface_pin_normal_i = 1'b0;
		ref_cnt                       = 0;
		bad_count                     = 0;
		checks_done                   = 0;
		repeat (2) @(posedge sys_clk_i);
		rst_b_i <= 1'b1;
		@(posedge sys_clk_i);
		#1;
		t_reset_values();
		t_readback();
		t_rates();
		t_pin();
		t_mid_reset();
		close_out();
	end
endmodule : pll_clock_select_config_tb_top
